/* File: verilog/pac_core.sv */
// pair arithmetic and accumulator rotate execution datapath
`include "pac_regs.svh"
`default_nettype none
module pac_core
  import pac_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // opcode byte stream, one byte per T-state when accepted
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte,
  output logic             op_ready,
  // timing markers
  output logic             t_state,
  output logic             m_end,
  output logic             done,
  // architectural state
  output logic [7:0]       acc,
  output logic [7:0]       flags,
  output logic [15:0]      pair_one,
  output logic [15:0]      pair_two,
  output logic [15:0]      pair_three,
  output logic [15:0]      index_x,
  output logic [15:0]      index_y,
  output logic [15:0]      stack_pointer
);
  // whole module state
  typedef struct packed {
    pac_state_type st;
    pac_kind_type  kind;
    logic          pfx_y;   // prefix seen was the second one
    logic [1:0]    sel;     // pair field of the opcode
    logic [4:0]    tcnt;    // T-states left in instruction
    logic [4:0]    tall;    // T-states of instruction
    logic          done;
    logic [7:0]    a;
    logic [7:0]    f;
    logic [15:0]   r1;
    logic [15:0]   r2;
    logic [15:0]   r3;
    logic [15:0]   xreg;
    logic [15:0]   yreg;
    logic [15:0]   stk;
  } pac_core_state_type;

  pac_core_state_type cur;       // registered state
  pac_core_state_type next_cur;  // next state
  pac_add_if          add_bus();  // adder bundle
  logic [15:0]        oper;      // selected add operand
  logic [15:0]        pair_val;  // selected general pair

  // one adder, used for the index add
  pac_adder u_add (
    .io (add_bus)
  );

  // add operand: index_y field decode
  always_comb
  begin
    case (cur.sel)
      2'b00:   oper = cur.r1;
      2'b01:   oper = cur.r2;
      2'b10:   oper = cur.yreg;
      default: oper = cur.stk;
    endcase
  end

  // general pair decode for inc and dec
  always_comb
  begin
    case (cur.sel)
      2'b00:   pair_val = cur.r1;
      2'b01:   pair_val = cur.r2;
      2'b10:   pair_val = cur.r3;
      default: pair_val = cur.stk;
    endcase
  end

  assign add_bus.a = cur.yreg;
  assign add_bus.b = oper;

  // sequencer and execution, writeback on last T-state
  always_comb
  begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      PAC_IDLE:
      begin
        if (op_valid)
        begin
          next_cur.sel = op_byte[5:4];
          if (op_byte == `PAC_PFX_X || op_byte == `PAC_PFX_Y)
          begin
            // prefix fetch is the first four T-states
            next_cur.pfx_y = (op_byte == `PAC_PFX_Y);
            next_cur.st    = PAC_PRE;
          end
          else if (op_byte == `PAC_OP_ROLC)
          begin
            next_cur.kind = PAC_K_ROLC;
            next_cur.tall = `PAC_T_ROT;
            next_cur.tcnt = `PAC_T_ROT - 5'd1;
            next_cur.st   = PAC_BUSY;
          end
          else if (op_byte == `PAC_OP_RLTC)
          begin
            next_cur.kind = PAC_K_RLTC;
            next_cur.tall = `PAC_T_ROT;
            next_cur.tcnt = `PAC_T_ROT - 5'd1;
            next_cur.st   = PAC_BUSY;
          end
          else if (op_byte == `PAC_OP_RORC)
          begin
            next_cur.kind = PAC_K_RORC;
            next_cur.tall = `PAC_T_ROT;
            next_cur.tcnt = `PAC_T_ROT - 5'd1;
            next_cur.st   = PAC_BUSY;
          end
          else if (op_byte[7:6] == 2'b00 &&
                   (op_byte[3:0] == `PAC_LOW_INC ||
                    op_byte[3:0] == `PAC_LOW_DEC))
          begin
            // one machine cycle of six T-states
            next_cur.kind = (op_byte[3:0] == `PAC_LOW_INC) ?
                            PAC_K_INC : PAC_K_DEC;
            next_cur.tall = `PAC_T_PAIR;
            next_cur.tcnt = `PAC_T_PAIR - 5'd1;
            next_cur.st   = PAC_BUSY;
          end
          // anything else is not ours and is dropped
        end
      end
      PAC_PRE:
      begin
        // byte after prefix picks the index operation
        if (op_valid)
        begin
          next_cur.sel = op_byte[5:4];
          next_cur.st  = PAC_BUSY;
          if (op_byte == `PAC_OP_INCIDX)
          begin
            next_cur.kind = cur.pfx_y ? PAC_K_INCY : PAC_K_INCX;
            next_cur.tall = `PAC_T_IDX;
          end
          else if (op_byte == `PAC_OP_DECIDX)
          begin
            next_cur.kind = cur.pfx_y ? PAC_K_DECY : PAC_K_DECX;
            next_cur.tall = `PAC_T_IDX;
          end
          else if (cur.pfx_y && op_byte[7:6] == 2'b00 &&
                   op_byte[3:0] == `PAC_LOW_ADD)
          begin
            next_cur.kind = PAC_K_ADDY;
            next_cur.tall = `PAC_T_ADD;
          end
          else
          begin
            // unsupported pair: abandon quietly
            next_cur.kind = PAC_K_NONE;
            next_cur.st   = PAC_IDLE;
          end
          // prefix already used four T-states, this one more
          next_cur.tcnt = next_cur.tall - `PAC_T_PFX - 5'd1;
        end
      end
      PAC_BUSY:
      begin
        if (cur.tcnt != 5'd0)
        begin
          next_cur.tcnt = cur.tcnt - 5'd1;
        end
        else
        begin
          // last T-state: commit the result
          next_cur.st   = PAC_IDLE;
          next_cur.done = 1'b1;
          case (cur.kind)
            PAC_K_ADDY:
            begin
              next_cur.yreg = add_bus.sum;
              next_cur.f[`PAC_F_H] = add_bus.h;
              next_cur.f[`PAC_F_N] = 1'b0;
              next_cur.f[`PAC_F_C] = add_bus.c;
            end
            PAC_K_INC, PAC_K_DEC:
            begin
              // flags untouched
              case (cur.sel)
                2'b00:   next_cur.r1 = (cur.kind == PAC_K_INC) ?
                                       pair_val + 16'h0001 :
                                       pair_val - 16'h0001;
                2'b01:   next_cur.r2 = (cur.kind == PAC_K_INC) ?
                                       pair_val + 16'h0001 :
                                       pair_val - 16'h0001;
                2'b10:   next_cur.r3 = (cur.kind == PAC_K_INC) ?
                                       pair_val + 16'h0001 :
                                       pair_val - 16'h0001;
                default: next_cur.stk = (cur.kind == PAC_K_INC) ?
                                       pair_val + 16'h0001 :
                                       pair_val - 16'h0001;
              endcase
            end
            PAC_K_INCX: next_cur.xreg = cur.xreg + 16'h0001;
            PAC_K_INCY: next_cur.yreg = cur.yreg + 16'h0001;
            PAC_K_DECX: next_cur.xreg = cur.xreg - 16'h0001;
            PAC_K_DECY: next_cur.yreg = cur.yreg - 16'h0001;
            PAC_K_ROLC:
            begin
              next_cur.a = {cur.a[6:0], cur.a[7]};
              next_cur.f[`PAC_F_C] = cur.a[7];
              next_cur.f[`PAC_F_H] = 1'b0;
              next_cur.f[`PAC_F_N] = 1'b0;
            end
            PAC_K_RLTC:
            begin
              next_cur.a = {cur.a[6:0], cur.f[`PAC_F_C]};
              next_cur.f[`PAC_F_C] = cur.a[7];
              next_cur.f[`PAC_F_H] = 1'b0;
              next_cur.f[`PAC_F_N] = 1'b0;
            end
            PAC_K_RORC:
            begin
              next_cur.a = {cur.a[0], cur.a[7:1]};
              next_cur.f[`PAC_F_C] = cur.a[0];
              next_cur.f[`PAC_F_H] = 1'b0;
              next_cur.f[`PAC_F_N] = 1'b0;
            end
            default: next_cur.done = 1'b0;
          endcase
        end
      end
      default: next_cur.st = PAC_IDLE;
    endcase
    if (!rst_n)
    begin
      // synchronous reset to constants only
      next_cur      = '0;
      next_cur.st   = PAC_IDLE;
      next_cur.kind = PAC_K_NONE;
      next_cur.a    = `PAC_RST_BYTE;
      next_cur.f    = `PAC_RST_BYTE;
      next_cur.stk  = `PAC_RST_WORD;
    end
  end

  // single state register
  always_ff @(posedge clk)
  begin
    cur <= next_cur;
  end

  // outputs; a new byte accepted in idle and after a prefix, never while busy
  assign op_ready      = (cur.st != PAC_BUSY);
  assign t_state       = (cur.st == PAC_BUSY);
  assign m_end         = t_state && (cur.tcnt == 5'd0);
  assign done          = cur.done;
  assign acc           = cur.a;
  assign flags         = cur.f;
  assign pair_one      = cur.r1;
  assign pair_two      = cur.r2;
  assign pair_three    = cur.r3;
  assign index_x       = cur.xreg;
  assign index_y       = cur.yreg;
  assign stack_pointer = cur.stk;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rot_left_a: assert property (cur.st == PAC_BUSY && cur.tcnt == 5'd0 &&
    cur.kind == PAC_K_ROLC |=> acc == {$past(acc[6:0]), $past(acc[7])}
    && flags[`PAC_F_C] == $past(acc[7]))
    else $error("left rotate result");
  rot_carry_a: assert property (cur.st == PAC_BUSY && cur.tcnt == 5'd0 &&
    cur.kind == PAC_K_RLTC |=> acc == {$past(acc[6:0]),
    $past(flags[`PAC_F_C])})
    else $error("rotate through carry result");
  rot_right_a: assert property (cur.st == PAC_BUSY && cur.tcnt == 5'd0 &&
    cur.kind == PAC_K_RORC |=> acc == {$past(acc[0]), $past(acc[7:1])}
    && flags[`PAC_F_C] == $past(acc[0]))
    else $error("right rotate result");
  rot_flags_a: assert property (done && $past(cur.kind) inside
    {PAC_K_ROLC, PAC_K_RLTC, PAC_K_RORC} |-> !flags[`PAC_F_H]
    && !flags[`PAC_F_N] && flags[7:5] == $past(flags[7:5], 2))
    else $error("rot flags");
  add_flags_a: assert property (cur.st == PAC_BUSY && cur.tcnt == 5'd0 &&
    cur.kind == PAC_K_ADDY |=> index_y == $past(add_bus.sum) &&
    flags[`PAC_F_H] == $past(add_bus.h) &&
    flags[`PAC_F_C] == $past(add_bus.c) && !flags[`PAC_F_N])
    else $error("index add");
  pair_time_a: assert property (op_ready && op_valid &&
    cur.st == PAC_IDLE && op_byte == 8'h03 |=> !done [*6] ##1 done)
    else $error("pair increment timing");
  pair_flags_a: assert property (done && $past(cur.kind) inside
    {PAC_K_INC, PAC_K_DEC, PAC_K_INCX, PAC_K_DECY, PAC_K_INCY,
     PAC_K_DECX} |-> flags == $past(flags)) else $error("flags moved");
  idx_time_a: assert property (cur.st == PAC_PRE && op_valid &&
    op_byte == 8'h23 |=> !done [*6] ##1 done)
    else $error("index increment timing");
  add_time_a: assert property (cur.st == PAC_PRE && op_valid && cur.pfx_y
    && op_byte == 8'h09 |=> !done [*8] ##1 !done [*3] ##1 done)
    else $error("index add timing");

  rolc_c: cover property (done && $past(cur.kind) == PAC_K_ROLC);
  addy_c: cover property (done && $past(cur.kind) == PAC_K_ADDY);
  decx_c: cover property (done && $past(cur.kind) == PAC_K_DECX);
endmodule
`default_nettype wire

/* File: verilog/pac_regs.svh */
// constants for the pair arithmetic and accumulator rotate datapath
// -----------------------------------------------------------------
// Overview of operation
// -----------------------------------------------------------------
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH
`define PAC_PFX_X      8'hDD
`define PAC_PFX_Y      8'hFD
`define PAC_OP_ROLC    8'h07
`define PAC_OP_RLTC    8'h17
`define PAC_OP_RORC    8'h0F
`define PAC_OP_INCIDX  8'h23
`define PAC_OP_DECIDX  8'h2B
`define PAC_LOW_ADD    4'h9
`define PAC_LOW_INC    4'h3
`define PAC_LOW_DEC    4'hB
`define PAC_T_ADD      5'd15
`define PAC_T_IDX      5'd10
`define PAC_T_PAIR     5'd6
`define PAC_T_ROT      5'd4
`define PAC_T_PFX      5'd4
`define PAC_M_ADD      3'd4
`define PAC_M_IDX      3'd2
`define PAC_M_ONE      3'd1
`define PAC_F_S        7
`define PAC_F_Z        6
`define PAC_F_H        4
`define PAC_F_PV       2
`define PAC_F_N        1
`define PAC_F_C        0
`define PAC_RST_WORD   16'h0000
`define PAC_RST_BYTE   8'h00
`endif

/* File: verilog/pac_pkg.sv */
// types shared by the datapath modules
`default_nettype none
package pac_pkg;
  typedef enum logic [1:0] {
    PAC_IDLE = 2'b00,
    PAC_PRE  = 2'b01,
    PAC_BUSY = 2'b10
  } pac_state_type;
  typedef enum logic [3:0] {
    PAC_K_NONE  = 4'h0,
    PAC_K_ADDY  = 4'h1,
    PAC_K_INC   = 4'h2,
    PAC_K_DEC   = 4'h3,
    PAC_K_INCX  = 4'h4,
    PAC_K_INCY  = 4'h5,
    PAC_K_DECX  = 4'h6,
    PAC_K_DECY  = 4'h7,
    PAC_K_ROLC  = 4'h8,
    PAC_K_RLTC  = 4'h9,
    PAC_K_RORC  = 4'hA
  } pac_kind_type;
endpackage
`default_nettype wire

/* File: verilog/pac_add_if.sv */
// operand and result bundle between sequencer and 16-bit adder
`default_nettype none
interface pac_add_if;
  logic [15:0] a;      // first operand
  logic [15:0] b;      // second operand
  logic [15:0] sum;    // result
  logic        h;      // carry out of bit 11
  logic        c;      // carry out of bit 15
  modport user (output a, output b, input sum, input h, input c);
  modport unit (input a, input b, output sum, output h, output c);
endinterface
`default_nettype wire

/* File: verilog/pac_adder.sv */
// 16-bit adder with nibble and word carries
`default_nettype none
module pac_adder
  import pac_pkg::*;
(
  // operand bundle
  pac_add_if.unit io
);
  logic [12:0] low;   // low twelve bits plus carry
  logic [16:0] full;  // whole sum plus carry
  // carries taken at bit 11 and bit 15
  always_comb
  begin
    low  = {1'b0, io.a[11:0]} + {1'b0, io.b[11:0]};
    full = {1'b0, io.a} + {1'b0, io.b};
  end
  assign io.sum = full[15:0];
  assign io.h   = low[12];
  assign io.c   = full[16];
endmodule
`default_nettype wire

/* File: dv/tb_pair_arith_and_acc_rotate.sv */
// self-checking bench for the pair arithmetic and rotate datapath
`include "pac_regs.svh"
`default_nettype none
module tb_pair_arith_and_acc_rotate
  import pac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  f;
    logic [15:0] p0, p1, p2, p3, xv, yv;
    logic [4:0]  n;
  } pac_exp_type;
  logic        clk, rst_n, op_valid, op_ready, t_state, m_end, done;
  logic [7:0]  op_byte, acc, flags;
  logic [15:0] pair_one, pair_two, pair_three;
  logic [15:0] index_x, index_y, stack_pointer;
  logic [7:0]  ma, mf;        // model accumulator and flags
  logic [15:0] mp [4];        // model pairs, field order
  logic [15:0] mx, my;        // model index registers
  pac_exp_type q [$];         // notes, oldest first
  int          n_fail, checks_done, cyc, t0, tc;
  logic        prev_me;       // m_end seen one edge earlier
  pac_core DUT (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_byte(op_byte), .op_ready(op_ready), .t_state(t_state),
    .m_end(m_end), .done(done), .acc(acc), .flags(flags),
    .pair_one(pair_one), .pair_two(pair_two),
    .pair_three(pair_three), .index_x(index_x), .index_y(index_y),
    .stack_pointer(stack_pointer));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare and closing tasks
  // ---------------------------------------------------------------
  task automatic cmp_val(input string nm, input logic [15:0] ev, sv);
    checks_done++;
    if (sv !== ev)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic cmp_cnt(input string nm, input int ev, sv);
    checks_done++;
    if (sv != ev)
    begin
      n_fail++;
      $display("unexpected %s: expected %0d seen %0d", nm, ev, sv);
    end
  endtask
  task automatic chk_state(input pac_exp_type e);
    cmp_val("acc", e.a, acc);
    cmp_val("flags", e.f, flags);
    cmp_val("pair_one", e.p0, pair_one);
    cmp_val("pair_two", e.p1, pair_two);
    cmp_val("pair_three", e.p2, pair_three);
    cmp_val("stack_pointer", e.p3, stack_pointer);
    cmp_val("index_x", e.xv, index_x);
    cmp_val("index_y", e.yv, index_y);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // driver tasks
  // ---------------------------------------------------------------
  // byte is held until its take, so bytes offered while busy are
  // refused and must not disturb the running instruction
  task automatic put_byte(input logic [7:0] b);
    int k;
    @(negedge clk);
    op_valid = 1'b1;
    op_byte  = b;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (op_ready !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      n_fail++;
      $display("unexpected op_ready: expected 1 seen %b", op_ready);
    end
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk);
      op_valid = 1'b0;
      op_byte  = 8'($urandom);  // junk must be ignored
    end
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst_n    = 1'b0;
    op_valid = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    ma = 8'h00;
    mf = 8'h00;
    mx = 16'h0000;
    my = 16'h0000;
    foreach (mp[i]) mp[i] = 16'h0000;
    q.delete();
    chk_state('0);
    cmp_val("op_ready", 16'h0001, {15'h0000, op_ready});
    cmp_val("done", 16'h0000, {15'h0000, done});
  endtask
  // issue one instruction and note its expected outcome
  task automatic issue(input logic [1:0] pfx, input logic [7:0] b);
    logic [16:0] s;
    logic [15:0] o;
    logic        c;
    logic [4:0]  n;
    n = 5'd0;
    if (pfx != 2'd0)
    begin
      put_byte(pfx == 2'd1 ? `PAC_PFX_X : `PAC_PFX_Y);
      idle($urandom % 2);      // gap after a prefix is legal
    end
    put_byte(b);
    if (pfx == 2'd0)
    begin
      c = b[3] ? ma[0] : ma[7];
      if (b == `PAC_OP_ROLC) ma = {ma[6:0], c};
      if (b == `PAC_OP_RLTC) ma = {ma[6:0], mf[0]};
      if (b == `PAC_OP_RORC) ma = {c, ma[7:1]};
      if (b == `PAC_OP_ROLC || b == `PAC_OP_RLTC || b == `PAC_OP_RORC)
      begin
        mf[0] = c;
        mf[4] = 1'b0;
        mf[1] = 1'b0;
        n = `PAC_T_ROT;
      end
      if (b[7:6] == 2'b00 && b[3:0] == `PAC_LOW_INC)
      begin
        mp[b[5:4]] = mp[b[5:4]] + 16'h0001;
        n = `PAC_T_PAIR;
      end
      if (b[7:6] == 2'b00 && b[3:0] == `PAC_LOW_DEC)
      begin
        mp[b[5:4]] = mp[b[5:4]] - 16'h0001;
        n = `PAC_T_PAIR;
      end
    end
    else if (b == `PAC_OP_INCIDX || b == `PAC_OP_DECIDX)
    begin
      o = b[3] ? 16'hFFFF : 16'h0001;
      if (pfx == 2'd1)
        mx = mx + o;
      else
        my = my + o;
      n = `PAC_T_IDX - `PAC_T_ROT;
    end
    else if (pfx == 2'd2 && b[7:6] == 2'b00 && b[3:0] == `PAC_LOW_ADD)
    begin
      o = (b[5:4] == 2'b10) ? my : mp[b[5:4]];
      s = {4'h0, {1'b0, my[11:0]} + {1'b0, o[11:0]}};
      mf[4] = s[12];
      s = {1'b0, my} + {1'b0, o};
      mf[1] = 1'b0;
      mf[0] = s[16];
      my = s[15:0];
      n = `PAC_T_ADD - `PAC_T_ROT;
    end
    if (n != 5'd0)
      q.push_back({ma, mf, mp[0], mp[1], mp[2], mp[3], mx, my, n});
    idle($urandom % 3);
  endtask
  // bootstrap: index_y to all ones, add with carry, carry into acc
  task automatic run_block(input int cnt);
    logic [7:0] b;
    int         r;
    issue(2'd2, `PAC_OP_DECIDX);
    issue(2'd2, 8'h29);
    issue(2'd0, `PAC_OP_RLTC);
    repeat (cnt)
    begin
      r = $urandom % 9;
      b = {2'b00, 2'($urandom), 4'h0};
      case (r)
        0: issue(2'd0, `PAC_OP_ROLC);
        1: issue(2'd0, `PAC_OP_RLTC);
        2: issue(2'd0, `PAC_OP_RORC);
        3: issue(2'd0, b | `PAC_LOW_INC);
        4: issue(2'd0, b | `PAC_LOW_DEC);
        5: issue(2'd1, $urandom % 2 ? `PAC_OP_INCIDX : `PAC_OP_DECIDX);
        6: issue(2'd2, $urandom % 2 ? `PAC_OP_INCIDX : `PAC_OP_DECIDX);
        7: issue(2'd2, b | `PAC_LOW_ADD);
        default: issue(2'($urandom % 2), b | `PAC_LOW_ADD); // dropped
      endcase
    end
    idle(14);
    cmp_cnt("pending notes", 0, q.size());
  endtask
  // ---------------------------------------------------------------
  // monitor: results are judged when done pulses
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (done === 1'b1)
    begin
      if (q.size() == 0)
        cmp_cnt("unnoted done", 0, 1);
      else
      begin
        chk_state(q[0]);
        cmp_cnt("latency", q[0].n + 1, cyc - t0);
        cmp_cnt("t_states", q[0].n, tc);
        cmp_val("m_end", 16'h0001, {15'h0000, prev_me});
        void'(q.pop_front());
      end
    end
    if (t_state === 1'b1)
      tc++;
    // every take restarts timing, so the second byte of a pair wins
    if (op_valid === 1'b1 && op_ready === 1'b1)
    begin
      t0 = cyc;
      tc = 0;
    end
    prev_me = m_end;
  end
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_byte = 8'h00;
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(54196));
    do_reset();
    run_block(300);
    do_reset();                // second reset in mid-run
    run_block(100);
    stop_test();
  end
  // about 7 cycles per instruction, with a wide margin
  initial
  begin
    #(20000 * 50);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
